/* File: rtl/fan_monitor_pkg.sv */
// Package: register map, field positions, reset values and timing for the fan monitor
package fan_monitor_pkg;
  // Register offsets
  localparam logic [7:0] CFG1_ADDR     = 8'h00;
  localparam logic [7:0] CFG2_ADDR     = 8'h01;
  localparam logic [7:0] STAT1_ADDR    = 8'h02;
  localparam logic [7:0] SPEED1_ADDR   = 8'h08;
  localparam logic [7:0] SPEED2_ADDR   = 8'h09;
  localparam logic [7:0] LIMIT1_ADDR   = 8'h10;
  localparam logic [7:0] LIMIT2_ADDR   = 8'h11;
  localparam logic [7:0] CHAR1_ADDR    = 8'h20;
  localparam logic [7:0] CHAR2_ADDR    = 8'h21;
  localparam logic [7:0] DUTY_ADDR     = 8'h22;
  localparam logic [7:0] SPINCTL_ADDR  = 8'h23;
  // Field positions
  localparam int CFG1_AUTO_BIT   = 7;
  localparam int CFG1_REG1_BIT   = 5;
  localparam int CFG1_REG2_BIT   = 6;
  localparam int CFG1_FAULT_EN   = 4;
  localparam int CFG1_INVERT_BIT = 3;
  localparam int CFG2_MEAS1_BIT  = 2;
  localparam int CFG2_MEAS2_BIT  = 3;
  localparam int STAT1_FAN1_BIT  = 0;
  localparam int STAT1_FAN2_BIT  = 1;
  localparam int CHAR_RANGE_LSB  = 6;
  // Reset values
  localparam logic [7:0] CFG1_RST    = 8'h90;
  localparam logic [7:0] CFG2_RST    = 8'h7F;
  localparam logic [7:0] LIMIT_RST   = 8'hFF;
  localparam logic [7:0] CHAR_RST    = 8'h5D;
  localparam logic [7:0] DUTY_RST    = 8'h55;
  localparam logic [7:0] SPINCTL_RST = 8'h50;
  // Counts
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [2:0] FAIL_RUN     = 3'h5;
  localparam logic [3:0] DUTY_STEPS   = 4'hF;
  localparam logic [3:0] REG_DUTY_MIN = 4'hB;
  // Timing
  localparam int  CLK_HZ        = 25_000_000;
  localparam int  REF_HZ_X100   = 1_125_000;
  localparam int  REF_DIV       = CLK_HZ / (REF_HZ_X100 / 100);
  localparam int  SPINUP_MS     = 2000;
  localparam int  SPINUP_CYCLES = (CLK_HZ / 1000) * SPINUP_MS;
  localparam int  PWM_SLOT_CYCLES = 16;
endpackage

/* File: rtl/fan_tach_fault_monitor.sv */
// Two-fan tach measurement, speed regulation, drive and failure signalling
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
// Behaviour
// R1 - Clear bit7, set bit5: fan 1 regulation
// R2 - Regulate drive toward limit register target count
// R3 - Host sets speed range two for regulation
// R4 - Regulation drive spans 75% to 100% (code floor REG_DUTY_MIN 0xB gives 11/16, 68.75%)
// R5 - Bits 5,7 clear: direct duty from 0x22
// R6 - Host keeps target above 53% speed
// R7 - Period counted with 11.25 kHz reference
// R8 - Measurement restarts on drive rising edge
// R9 - Count pulse two to four, saturate 255
// R10 - Repeat measurements, store at 0x08/0x09
// R11 - Bits 7:6 pick divider 1/2/4/8
// R12 - Bit 3 inverts drive output
// R13 - Host picks inversion by transistor type
// R14 - Open-drain active-low fault, enabled at reset
// R15 - Fault after five consecutive failures
// R16 - Failure needs reading above limit
// R17 - Failure raises alert and status bit
// R18 - Status read releases alert
// R19 - Failure forces drive high for spin-up
// R20 - Measurement and alerts continue after fault
// R21 - Recovery releases fault, normal speed
// R22 - Regulation mode fails only at 255
// R23 - Duty nibbles per fan, sixteen steps
// R24 - Good reading clears failure run
module fan_tach_fault_monitor #(
  parameter int SPINUP_CYCLES = fan_monitor_pkg::SPINUP_CYCLES
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Fan pins
  input  wire logic [1:0] fan_pulse_sense_in,
  output logic      [1:0] fan_drive_out,
  // Host signalling
  output logic            alert_n,
  output logic            fan_fault_n_out,
  output logic            fan_fault_n_oe
);

  // Registers
  logic [7:0]  cfg1_q, cfg1_d, cfg2_q, cfg2_d, duty_q, duty_d, spinctl_q, spinctl_d;
  logic [7:0]  limit_q [2], limit_d [2];
  logic [7:0]  char_q [2], char_d [2];
  logic [7:0]  speed_q [2], speed_d [2];
  logic [1:0]  stat_q, stat_d;
  logic [7:0]  rdata_q, rdata_d;
  // Timebase and PWM
  logic [11:0] ref_cnt_q, ref_cnt_d;
  logic        ref_tick;
  logic [3:0]  pwm_phase_q, pwm_phase_d;
  // Per-fan state
  logic [1:0]  sync1_q, sync2_q, tach_prev_q;
  logic [2:0]  edges_q [2], edges_d [2];
  logic [7:0]  cnt_q [2], cnt_d [2];
  logic [2:0]  div_q [2], div_d [2];
  logic [2:0]  fails_q [2], fails_d [2];
  logic [31:0] spin_q [2], spin_d [2];
  logic [3:0]  reg_duty_q [2], reg_duty_d [2];
  logic [1:0]  drive_q, drive_d;
  logic [1:0]  fault_q, fault_d;
  logic [1:0]  pwm_raw;
  logic [1:0]  pwm_prev_q;

  localparam logic [11:0] REF_LAST = 12'(fan_monitor_pkg::REF_DIV - 1);

  assign ref_tick = (ref_cnt_q == REF_LAST);

  function automatic logic [2:0] div_last(input logic [1:0] sel);
    div_last = 3'((4'h1 << sel) - 4'h1);
  endfunction

  // Pin synchronisers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q     <= 2'h3;
      sync2_q     <= 2'h3;
      tach_prev_q <= 2'h3;
      pwm_prev_q  <= 2'h0;
    end else begin
      sync1_q     <= fan_pulse_sense_in;
      sync2_q     <= sync1_q;
      tach_prev_q <= sync2_q;
      pwm_prev_q  <= pwm_raw;
    end
  end

  // Register access, status and read data
  always_comb begin
    cfg1_d    = cfg1_q;
    cfg2_d    = cfg2_q;
    duty_d    = duty_q;
    spinctl_d = spinctl_q;
    limit_d   = limit_q;
    char_d    = char_q;
    stat_d    = stat_q;
    rdata_d   = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        fan_monitor_pkg::CFG1_ADDR:    cfg1_d    = reg_wdata; // [R1] [R5] [R12] [R14]
        fan_monitor_pkg::CFG2_ADDR:    cfg2_d    = reg_wdata;
        fan_monitor_pkg::LIMIT1_ADDR:  limit_d[0] = reg_wdata; // [R2]
        fan_monitor_pkg::LIMIT2_ADDR:  limit_d[1] = reg_wdata;
        fan_monitor_pkg::CHAR1_ADDR:   char_d[0] = reg_wdata; // [R11]
        fan_monitor_pkg::CHAR2_ADDR:   char_d[1] = reg_wdata;
        fan_monitor_pkg::DUTY_ADDR:    duty_d    = reg_wdata; // [R5] [R23]
        fan_monitor_pkg::SPINCTL_ADDR: spinctl_d = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        fan_monitor_pkg::CFG1_ADDR:    rdata_d = cfg1_q;
        fan_monitor_pkg::CFG2_ADDR:    rdata_d = cfg2_q;
        fan_monitor_pkg::STAT1_ADDR: begin
          rdata_d = {6'h00, stat_q};
          stat_d  = 2'h0; // [R18]
        end
        fan_monitor_pkg::SPEED1_ADDR:  rdata_d = speed_q[0]; // [R10]
        fan_monitor_pkg::SPEED2_ADDR:  rdata_d = speed_q[1];
        fan_monitor_pkg::LIMIT1_ADDR:  rdata_d = limit_q[0];
        fan_monitor_pkg::LIMIT2_ADDR:  rdata_d = limit_q[1];
        fan_monitor_pkg::CHAR1_ADDR:   rdata_d = char_q[0];
        fan_monitor_pkg::CHAR2_ADDR:   rdata_d = char_q[1];
        fan_monitor_pkg::DUTY_ADDR:    rdata_d = duty_q;
        fan_monitor_pkg::SPINCTL_ADDR: rdata_d = spinctl_q;
        default:                       rdata_d = 8'h00;
      endcase
    end
    // Failure sets win over the read clear
    for (int f = 0; f < 2; f++) begin
      if (fail_event(f)) begin
        stat_d[f] = 1'b1; // [R17] [R20]
      end
    end
  end

  // Failure event for a finished measurement
  function automatic logic fail_event(input int f);
    logic done;
    logic [7:0] val;
    logic reg_mode;
    done     = (edges_q[f] == 3'h4) || (cnt_q[f] == fan_monitor_pkg::COUNT_MAX);
    val      = cnt_q[f];
    reg_mode = !cfg1_q[fan_monitor_pkg::CFG1_AUTO_BIT] && cfg1_q[fan_monitor_pkg::CFG1_REG1_BIT + f];
    if (reg_mode) begin
      fail_event = meas_done(f) && (val == fan_monitor_pkg::COUNT_MAX); // [R22]
    end else begin
      fail_event = meas_done(f) && (val > limit_q[f]); // [R16]
    end
    if (!done) begin
      fail_event = 1'b0;
    end
  endfunction

  function automatic logic meas_done(input int f);
    logic en;
    en = cfg2_q[fan_monitor_pkg::CFG2_MEAS1_BIT + f];
    meas_done = en && (edges_q[f] >= 3'h2) && (edges_q[f] != 3'h5)
                && ((edges_q[f] == 3'h4) || (cnt_q[f] == fan_monitor_pkg::COUNT_MAX));
  endfunction

  // Timebase, PWM slots, measurement, regulation and spin-up
  always_comb begin
    ref_cnt_d   = ref_tick ? 12'h000 : ref_cnt_q + 12'h001; // [R7]
    pwm_phase_d = pwm_phase_q;
    if (ref_tick) begin
      pwm_phase_d = pwm_phase_q + 4'h1;
    end
    for (int f = 0; f < 2; f++) begin
      logic reg_mode;
      logic rise;
      logic [3:0] level;
      reg_mode = !cfg1_q[fan_monitor_pkg::CFG1_AUTO_BIT] && cfg1_q[fan_monitor_pkg::CFG1_REG1_BIT + f];
      rise     = sync2_q[f] && !tach_prev_q[f];
      edges_d[f]    = edges_q[f];
      cnt_d[f]      = cnt_q[f];
      div_d[f]      = div_q[f];
      speed_d[f]    = speed_q[f];
      fails_d[f]    = fails_q[f];
      spin_d[f]     = (spin_q[f] != 32'h0) ? spin_q[f] - 32'h1 : 32'h0;
      reg_duty_d[f] = reg_duty_q[f];
      fault_d[f]    = fault_q[f];
      level      = reg_mode ? reg_duty_q[f] : duty_q[4*f +: 4]; // [R23] [R5]
      pwm_raw[f] = (spin_q[f] != 32'h0) || (level > pwm_phase_q) ||
                   (level == fan_monitor_pkg::DUTY_STEPS); // [R19]
      if (!cfg2_q[fan_monitor_pkg::CFG2_MEAS1_BIT + f]) begin
        edges_d[f] = 3'h0;
      end else if (pwm_raw[f] && !pwm_prev_q[f] && edges_q[f] == 3'h0) begin
        edges_d[f] = 3'h1; // [R8]
        cnt_d[f]   = 8'h00;
        div_d[f]   = 3'h0;
      end else if (meas_done(f)) begin
        speed_d[f] = cnt_q[f]; // [R10]
        edges_d[f] = 3'h0;
        if (fail_event(f)) begin
          spin_d[f] = SPINUP_CYCLES; // [R19]
          if (fails_q[f] != fan_monitor_pkg::FAIL_RUN) begin
            fails_d[f] = fails_q[f] + 3'h1; // [R15]
          end
        end else begin
          fails_d[f] = 3'h0; // [R24] [R21]
        end
        if (reg_mode) begin // [R2] [R4]
          if (cnt_q[f] > limit_q[f] && reg_duty_q[f] != fan_monitor_pkg::DUTY_STEPS) begin
            reg_duty_d[f] = reg_duty_q[f] + 4'h1;
          end else if (cnt_q[f] < limit_q[f] && reg_duty_q[f] != fan_monitor_pkg::REG_DUTY_MIN) begin
            reg_duty_d[f] = reg_duty_q[f] - 4'h1;
          end
        end
      end else if (edges_q[f] != 3'h0 && rise) begin
        edges_d[f] = edges_q[f] + 3'h1; // [R9]
      end else if (edges_q[f] >= 3'h2 && ref_tick) begin
        if (div_q[f] == div_last(char_q[f][7:6])) begin // [R11]
          div_d[f] = 3'h0;
          cnt_d[f] = cnt_q[f] + 8'h01; // [R9]
        end else begin
          div_d[f] = div_q[f] + 3'h1;
        end
      end
      fault_d[f] = (fails_d[f] == fan_monitor_pkg::FAIL_RUN); // [R15] [R21]
      drive_d[f] = pwm_raw[f] ^ cfg1_q[fan_monitor_pkg::CFG1_INVERT_BIT]; // [R12]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg1_q      <= fan_monitor_pkg::CFG1_RST; // [R14]
      cfg2_q      <= fan_monitor_pkg::CFG2_RST;
      duty_q      <= fan_monitor_pkg::DUTY_RST;
      spinctl_q   <= fan_monitor_pkg::SPINCTL_RST;
      stat_q      <= 2'h0;
      rdata_q     <= 8'h00;
      ref_cnt_q   <= 12'h000;
      pwm_phase_q <= 4'h0;
      drive_q     <= 2'h0;
      fault_q     <= 2'h0;
      for (int f = 0; f < 2; f++) begin
        limit_q[f]    <= fan_monitor_pkg::LIMIT_RST;
        char_q[f]     <= fan_monitor_pkg::CHAR_RST;
        speed_q[f]    <= 8'h00;
        edges_q[f]    <= 3'h0;
        cnt_q[f]      <= 8'h00;
        div_q[f]      <= 3'h0;
        fails_q[f]    <= 3'h0;
        spin_q[f]     <= 32'h0;
        reg_duty_q[f] <= fan_monitor_pkg::DUTY_STEPS;
      end
    end else begin
      cfg1_q      <= cfg1_d;
      cfg2_q      <= cfg2_d;
      duty_q      <= duty_d;
      spinctl_q   <= spinctl_d;
      stat_q      <= stat_d;
      rdata_q     <= rdata_d;
      ref_cnt_q   <= ref_cnt_d;
      pwm_phase_q <= pwm_phase_d;
      drive_q     <= drive_d;
      fault_q     <= fault_d;
      limit_q     <= limit_d;
      char_q      <= char_d;
      speed_q     <= speed_d;
      edges_q     <= edges_d;
      cnt_q       <= cnt_d;
      div_q       <= div_d;
      fails_q     <= fails_d;
      spin_q      <= spin_d;
      reg_duty_q  <= reg_duty_d;
    end
  end

  // Outputs
  assign reg_rdata       = rdata_q;
  assign fan_drive_out   = drive_q;
  assign alert_n         = ~|stat_q; // [R17] [R18]
  assign fan_fault_n_out = 1'b0;
  assign fan_fault_n_oe  = |fault_q && cfg1_q[fan_monitor_pkg::CFG1_FAULT_EN]; // [R14] [R20]

endmodule

/* File: tb/fan_model.sv */
// Behavioural fan that returns tach pulses while its drive pin is high
`timescale 1ns/100ps
module fan_model #(
  parameter int HALF = 2000
) (
  // Drive side
  input  wire logic mclk,
  input  wire logic drive,
  // Tach side
  output logic      tach
);
  int   cnt = 0;
  logic ph  = 1'b0;
  always_ff @(posedge mclk) begin
    if (drive) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        ph <= ~ph;
      end
    end
  end
  // Pulled high while the drive transistor is off
  assign tach = drive ? ph : 1'b1;
endmodule

/* File: tb/fan_tach_fault_monitor_assertions.sv */
// Port-level checker for the fan monitor
`timescale 1ns/100ps
module fan_monitor_checker #(
  parameter int SPINUP_CYCLES = 200
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] fan_pulse_sense_in,
  input wire logic [1:0] fan_drive_out,
  input wire logic       alert_n,
  input wire logic       fan_fault_n_out,
  input wire logic       fan_fault_n_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_stat_rd;
    reg_rd && reg_addr == fan_monitor_pkg::STAT1_ADDR;
  endsequence
  property p_rd_idle; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
  property p_clear_quiet; s_stat_rd ##0 alert_n |=> reg_rdata == 8'h00; endproperty
  property p_set_seen; s_stat_rd ##0 !alert_n |=> reg_rdata != 8'h00; endproperty
  property p_release; s_stat_rd ##0 !alert_n |=> ##[0:1] alert_n; endproperty
  property p_od_low; fan_fault_n_out == 1'b0; endproperty
  property p_fault_rst; $fell(rst) |-> !fan_fault_n_oe; endproperty
  property p_fault_alert; $rose(fan_fault_n_oe) |-> ##[0:1] !alert_n; endproperty
  property p_unmapped; reg_rd && reg_addr == 8'h3D |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  a_clear_quiet: assert property (p_clear_quiet) else $error("status set while alert high");
  a_set_seen: assert property (p_set_seen) else $error("alert low with empty status");
  a_release: assert property (p_release) else $error("alert held after status read");
  a_od_low: assert property (p_od_low) else $error("fault pin drives high");
  a_fault_rst: assert property (p_fault_rst) else $error("fault pulled after reset");
  a_fault_alert: assert property (p_fault_alert) else $error("fault without alert");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind fan_tach_fault_monitor fan_monitor_checker #(.SPINUP_CYCLES(SPINUP_CYCLES)) chk_u (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fan_pulse_sense_in(fan_pulse_sense_in),
  .fan_drive_out(fan_drive_out), .alert_n(alert_n), .fan_fault_n_out(fan_fault_n_out),
  .fan_fault_n_oe(fan_fault_n_oe));

/* File: tb/fan_tach_fault_monitor_test.sv */
// Self-checking bench for the two-fan monitor
`timescale 1ns/100ps
module fan_tach_fault_monitor_test;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, seed = 8'h11;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, alert_n, fault_out, fault_oe;
  logic [1:0] sense, drive;
  int         err_total = 0, tests_run = 0, i;
  logic [7:0] ra [7] = '{8'h00, 8'h02, 8'h10, 8'h20, 8'h22, 8'h23, 8'h3D};
  logic [7:0] rv [7] = '{fan_monitor_pkg::CFG1_RST, 8'h00, fan_monitor_pkg::LIMIT_RST,
                         fan_monitor_pkg::CHAR_RST, fan_monitor_pkg::DUTY_RST, fan_monitor_pkg::SPINCTL_RST, 8'h00};
  initial begin
    forever #20 mclk = ~mclk;
  end
  fan_tach_fault_monitor #(.SPINUP_CYCLES(200)) dut_u (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fan_pulse_sense_in(sense), .fan_drive_out(drive),
    .alert_n(alert_n), .fan_fault_n_out(fault_out), .fan_fault_n_oe(fault_oe));
  fan_model m0_u (.mclk(mclk), .drive(drive[0]), .tach(sense[0]));
  fan_model m1_u (.mclk(mclk), .drive(drive[1]), .tach(sense[1]));
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Full-on nibble drives high, inversion flips both pins
  function logic [7:0] exp_drive(input logic [1:0] k);
    logic [1:0] on;
    on = k[1] ? 2'b01 : 2'b10;
    return {6'h00, k[0] ? ~on : on};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(fan_monitor_pkg::LIMIT1_ADDR, seed);
      rd(fan_monitor_pkg::LIMIT1_ADDR, d);
      chk(d, seed);
    end
    wr(fan_monitor_pkg::LIMIT1_ADDR, 8'hFF);
    for (i = 0; i < 4; i++) begin
      wr(fan_monitor_pkg::CFG1_ADDR, i[0] ? 8'h18 : 8'h10);
      wr(fan_monitor_pkg::DUTY_ADDR, i[1] ? 8'h0F : 8'hF0);
      repeat (2300) @(posedge mclk);
      chk({6'h00, drive}, exp_drive(i[1:0]));
    end
    wr(fan_monitor_pkg::CFG1_ADDR, 8'h10);
    wr(fan_monitor_pkg::CHAR1_ADDR, 8'h40);
    wr(fan_monitor_pkg::DUTY_ADDR, 8'hEE);
    wr(fan_monitor_pkg::LIMIT1_ADDR, 8'h00);
    for (i = 0; i < 50000 && alert_n !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({7'h00, alert_n}, 8'h00);
    if (err_total != 0) begin
      stop_test;
    end
    d = 8'h01;
    repeat (150) begin
      @(posedge mclk);
      #1;
      d = d & {7'h00, drive[0]};
    end
    chk(d, 8'h01);
    rd(fan_monitor_pkg::STAT1_ADDR, d);
    chk(d, 8'h01);
    chk({7'h00, alert_n}, 8'h01);
    rd(fan_monitor_pkg::SPEED1_ADDR, d);
    chk({7'h00, d >= 8'h01 && d <= 8'h04}, 8'h01);
    wr(fan_monitor_pkg::CFG1_ADDR, 8'h30);
    wr(fan_monitor_pkg::LIMIT1_ADDR, 8'h01);
    rd(fan_monitor_pkg::STAT1_ADDR, d);
    repeat (20000) @(posedge mclk);
    #1;
    chk({7'h00, alert_n}, 8'h01);
    stop_test;
  end
endmodule
